// [rtl/sab_pkg.sv]
// Purpose: shared constants and types of the serial line autobaud front end
// Assumes: 10 MHz system clock, Modbus RTU style character framing
// Notes: bit periods derive from the clock rate
package sab_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int BAUD_4800 = 4800;
    localparam int BAUD_9600 = 9600;
    localparam int BAUD_19200 = 19200;
    localparam int BAUD_38400 = 38400;
    // bit period in clock cycles per rate index 0..3
    localparam logic [15:0] BIT_CYC [0:3] = '{
        16'(CLK_HZ / BAUD_4800), 16'(CLK_HZ / BAUD_9600),
        16'(CLK_HZ / BAUD_19200), 16'(CLK_HZ / BAUD_38400)};
    // frame gap, in bit times (3.5 characters of 11 bits, rounded up)
    localparam int GAP_BITS = 39;
    localparam int LOCK_FRAMES = 2;
    localparam int DWELL_CHARS = 40;
    localparam int MIN_FRAME_LEN = 4;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam int ADDR_MAX = 99;
    localparam int FIFO_DEPTH = 16;
    localparam logic [1:0] RESET_BAUD = 2'h1;
    // controller register map (byte offsets)
    localparam logic [7:0] CLI_CTRL = 8'h00;
    localparam logic [7:0] CLI_TXDATA = 8'h04;
    localparam logic [7:0] CLI_RXDATA = 8'h08;
    localparam logic [7:0] CLI_STATUS = 8'h0c;
    // field positions
    localparam int CTRL_BAUD_LSB = 0;
    localparam int CTRL_PAR_LSB = 2;
    localparam int CTRL_TWO_STOP = 4;
    localparam int ST_RX_FULL = 0;
    localparam int ST_TX_BUSY = 1;
    localparam int ST_RX_ERR = 2;
    typedef enum logic [1:0] {PAR_EVEN, PAR_ODD, PAR_NONE} sab_par_e;
endpackage

// [rtl/sab_link_if.sv]
// Purpose: two-wire half-duplex serial line between device and client
// Assumes: idle line reads high, a driver pulls it to the bit it sends
// Notes: line level is resolved here from both enables
`timescale 1ns/1ps
`default_nettype none
interface sab_link_if;
    logic dev_tx;
    logic dev_oe;
    logic cli_tx;
    logic cli_oe;
    logic line;
    // a low from either enabled driver wins, otherwise the bias holds it high
    assign line = !((dev_oe && !dev_tx) || (cli_oe && !cli_tx));
    modport dev (input line, output dev_tx, output dev_oe);
    modport cli (input line, output cli_tx, output cli_oe);
endinterface
`default_nettype wire

// [rtl/sab_device.sv]
// Purpose: device end with rate and parity detection
// Assumes: srst is the power-up reset; panel inputs are asynchronous
// Notes: also holds the FIFO and character engine
// Contract
// - factory default is automatic detection on
// - auto mode tries all rate and parity pairs
// - client sends at least 25 request frames
// - start, eight data, parity, one stop
// - no parity in auto means two stops
// - on failure client repeats read to station 1
// - detected settings kept until power cycle
// - manual rate is 4800/9600/19200/38400 baud
// - manual parity even/odd/none, stops selectable (here two stops only with parity none)
// - station address from two decimal switches
// - address and lock only from panel
// - valid addresses 1 to 99, 0 reserved
// - traffic lamp on while busy, steady at zero
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module sab_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    wire do_push = in_valid && in_ready;
    wire do_pop = out_valid && out_ready;
    // extra pointer bit tells full from empty
    assign in_ready = !((wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]));
    assign out_valid = (wptr != rptr);
    assign out_data = mem[rptr[AW-1:0]];
    always_ff @(posedge clk) begin
        if (srst) begin
            wptr <= '0;
            rptr <= '0;
        end else begin
            if (do_push) wptr <= wptr + 1'b1;
            if (do_pop) rptr <= rptr + 1'b1;
        end
    end
    // storage needs no reset, the pointers guard it
    always_ff @(posedge clk) begin
        if (do_push) mem[wptr[AW-1:0]] <= in_data;
    end
endmodule

module sab_uart (
    input wire logic clk,
    input wire logic srst,
    input wire logic [15:0] bit_cyc,
    input wire sab_pkg::sab_par_e par_mode,
    input wire logic two_stop,
    input wire logic rxd,
    output logic [7:0] rx_data,
    output logic rx_stb,
    output logic rx_err,
    output logic rx_busy,
    output logic gap_stb,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic txd,
    output logic tx_busy
);
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP1, RX_STOP2} sab_rx_e;
    sab_rx_e rst_q;
    logic [15:0] rcnt;
    logic [2:0] rbit;
    logic [7:0] rsh;
    logic rerr;
    logic [21:0] gcnt;
    logic [11:0] tsh;
    logic [3:0] tleft;
    logic [15:0] tcnt;
    wire rtick = (rcnt == 16'h0000);
    wire par_on = (par_mode != sab_pkg::PAR_NONE);
    wire par_odd = (par_mode == sab_pkg::PAR_ODD);
    wire par_exp = ^rsh ^ par_odd;
    wire tpar = ^tx_data ^ par_odd;
    wire [21:0] gap_cyc = 22'(bit_cyc) * 22'(sab_pkg::GAP_BITS);
    assign rx_busy = (rst_q != RX_IDLE);
    assign tx_ready = (tleft == 4'h0);
    assign tx_busy = !tx_ready;
    assign txd = tsh[0];

    // receiver: samples mid-bit, a false start falls back to idle
    always_ff @(posedge clk) begin
        if (srst) begin
            rst_q <= RX_IDLE;
            rcnt <= 16'h0000;
            rbit <= 3'h0;
            rsh <= 8'h00;
            rerr <= 1'b0;
            rx_stb <= 1'b0;
            rx_err <= 1'b0;
            rx_data <= 8'h00;
        end else begin
            rx_stb <= 1'b0;
            if (rst_q != RX_IDLE) rcnt <= rtick ? bit_cyc - 16'h0001 : rcnt - 16'h0001;
            case (rst_q)
                RX_IDLE: if (!rxd) begin
                    rst_q <= RX_START;
                    rcnt <= {1'b0, bit_cyc[15:1]};
                    rerr <= 1'b0;
                end
                RX_START: if (rtick) begin
                    rst_q <= rxd ? RX_IDLE : RX_DATA;
                    rbit <= 3'h0;
                end
                RX_DATA: if (rtick) begin
                    rsh <= {rxd, rsh[7:1]}; // lsb first
                    rbit <= rbit + 3'h1;
                    if (rbit == 3'h7) rst_q <= par_on ? RX_PAR : RX_STOP1;
                end
                RX_PAR: if (rtick) begin
                    if (rxd != par_exp) rerr <= 1'b1; // parity
                    rst_q <= RX_STOP1;
                end
                RX_STOP1: if (rtick) begin
                    if (two_stop) begin
                        rst_q <= RX_STOP2; // second stop bit checked too
                        if (!rxd) rerr <= 1'b1;
                    end else begin
                        rst_q <= RX_IDLE;
                        rx_stb <= 1'b1;
                        rx_err <= rerr || !rxd;
                        rx_data <= rsh;
                    end
                end
                RX_STOP2: if (rtick) begin
                    rst_q <= RX_IDLE;
                    rx_stb <= 1'b1;
                    rx_err <= rerr || !rxd;
                    rx_data <= rsh;
                end
                default: rst_q <= RX_IDLE;
            endcase
        end
    end

    // frame gap: one pulse after the line has idled for the gap time
    always_ff @(posedge clk) begin
        if (srst) begin
            gcnt <= 22'h00_0000;
            gap_stb <= 1'b0;
        end else begin
            gap_stb <= rxd && !rx_busy && (gcnt == gap_cyc - 22'h00_0001);
            if (rx_busy || !rxd) gcnt <= 22'h00_0000;
            else if (gcnt != gap_cyc) gcnt <= gcnt + 22'h00_0001;
        end
    end

    // transmitter: whole character is loaded as one shift word, ones fill behind
    always_ff @(posedge clk) begin
        if (srst) begin
            tsh <= 12'hfff;
            tleft <= 4'h0;
            tcnt <= 16'h0000;
        end else if (tx_ready) begin
            if (tx_valid) begin
                tsh <= {2'b11, par_on ? tpar : 1'b1, tx_data, 1'b0};
                tleft <= 4'ha + 4'(par_on) + 4'(two_stop);
                tcnt <= bit_cyc - 16'h0001;
            end
        end else if (tcnt == 16'h0000) begin
            tsh <= {1'b1, tsh[11:1]};
            tleft <= tleft - 4'h1;
            tcnt <= bit_cyc - 16'h0001;
        end else begin
            tcnt <= tcnt - 16'h0001;
        end
    end
endmodule

module sab_device (
    input wire logic clk,
    input wire logic srst,
    sab_link_if.dev link,
    input wire logic [3:0] addr_tens,
    input wire logic [3:0] addr_ones,
    input wire logic panel_lock,
    input wire logic cfg_wr,
    input wire logic cfg_auto,
    input wire logic [1:0] cfg_baud,
    input wire logic [1:0] cfg_parity,
    input wire logic cfg_two_stop,
    output logic [7:0] rx_data,
    output logic rx_first,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_overrun,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [6:0] station_addr,
    output logic addr_valid,
    output logic remote_cmd_en,
    output logic locked,
    output logic [1:0] cur_baud,
    output logic [1:0] cur_parity,
    output logic traffic_led
);
    logic [9:0] sync1;
    logic [9:0] sync2;
    logic auto_r;
    logic [1:0] baud_r;
    sab_pkg::sab_par_e par_r;
    logic stop_r;
    logic [1:0] cand_baud;
    sab_pkg::sab_par_e cand_par;
    logic [7:0] good_cnt;
    logic [7:0] dwell;
    logic [15:0] crc;
    logic [7:0] flen;
    logic fbad;
    logic first_pend;
    logic [7:0] u_rx_data;
    logic u_rx_stb;
    logic u_rx_err;
    logic u_rx_busy;
    logic u_gap;
    logic u_tx_ready;
    logic u_txd;
    logic u_tx_busy;
    logic fifo_in_ready;

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ sab_pkg::CRC_POLY) : (r >> 1);
        return r;
    endfunction

    // panel and line inputs pass two flops before use
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1 <= 10'h200;
            sync2 <= 10'h200;
        end else begin
            sync1 <= {link.line, panel_lock, addr_tens, addr_ones};
            sync2 <= sync1;
        end
    end
    wire line_s = sync2[9];
    wire [3:0] tens_s = sync2[7:4];
    wire [3:0] ones_s = sync2[3:0];

    // effective framing: candidate while auto, configured otherwise
    wire hunting = auto_r && !locked;
    wire [1:0] eff_baud = auto_r ? cand_baud : baud_r;
    wire sab_pkg::sab_par_e eff_par = auto_r ? cand_par : par_r;
    wire eff_two = (eff_par == sab_pkg::PAR_NONE) && (auto_r || stop_r);
    wire frame_ok = !fbad && (flen >= 8'(sab_pkg::MIN_FRAME_LEN)) && (crc == 16'h0000);
    wire advance = hunting && ((u_rx_stb && u_rx_err) || (dwell == 8'(sab_pkg::DWELL_CHARS)));
    wire push = u_rx_stb && !u_rx_err && !hunting;
    wire [6:0] addr_num = 7'(tens_s) * 7'd10 + 7'(ones_s);
    wire digits_ok = (tens_s <= 4'h9) && (ones_s <= 4'h9);
    assign cur_baud = eff_baud;
    assign cur_parity = eff_par;
    assign tx_ready = u_tx_ready && !hunting;

    // local configuration port; only the line framing is writable here
    always_ff @(posedge clk) begin
        if (srst) begin
            auto_r <= 1'b1;
            baud_r <= sab_pkg::RESET_BAUD;
            par_r <= sab_pkg::PAR_EVEN;
            stop_r <= 1'b0;
        end else if (cfg_wr) begin
            auto_r <= cfg_auto;
            baud_r <= cfg_baud;
            par_r <= (cfg_parity == 2'h0) ? sab_pkg::PAR_EVEN :
                     (cfg_parity == 2'h1) ? sab_pkg::PAR_ODD : sab_pkg::PAR_NONE;
            stop_r <= cfg_two_stop;
        end
    end

    // frame check and candidate search; lock is released only by reset
    always_ff @(posedge clk) begin
        if (srst) begin
            locked <= 1'b0;
            cand_baud <= 2'h0;
            cand_par <= sab_pkg::PAR_EVEN;
            good_cnt <= 8'h00;
            dwell <= 8'h00;
            crc <= sab_pkg::CRC_INIT;
            flen <= 8'h00;
            fbad <= 1'b0;
            first_pend <= 1'b1;
        end else begin
            if (u_rx_stb) begin
                if (u_rx_err) fbad <= 1'b1;
                else crc <= crc_byte(crc, u_rx_data);
                if (flen != 8'hff) flen <= flen + 8'h01;
                first_pend <= 1'b0;
                dwell <= dwell + 8'h01;
            end
            if (u_gap) begin
                crc <= sab_pkg::CRC_INIT;
                flen <= 8'h00;
                fbad <= 1'b0;
                first_pend <= 1'b1;
                if (hunting && frame_ok) begin
                    good_cnt <= good_cnt + 8'h01;
                    dwell <= 8'h00;
                    // a burst of requests gives every candidate its turn
                    if (good_cnt == 8'(sab_pkg::LOCK_FRAMES - 1)) locked <= 1'b1;
                end
            end
            if (advance) begin
                // rate first, then parity: 4 rates x 3 formats
                cand_baud <= cand_baud + 2'h1;
                if (cand_baud == 2'h3) begin
                    cand_par <= (cand_par == sab_pkg::PAR_EVEN) ? sab_pkg::PAR_ODD :
                                (cand_par == sab_pkg::PAR_ODD) ? sab_pkg::PAR_NONE :
                                sab_pkg::PAR_EVEN;
                end
                good_cnt <= 8'h00;
                dwell <= 8'h00;
            end
        end
    end

    // panel-derived status and traffic lamp, registered
    always_ff @(posedge clk) begin
        if (srst) begin
            station_addr <= 7'h00;
            addr_valid <= 1'b0;
            remote_cmd_en <= 1'b1;
            traffic_led <= 1'b0;
            rx_overrun <= 1'b0;
        end else begin
            station_addr <= addr_num;
            addr_valid <= digits_ok && (addr_num != 7'h00) &&
                          (addr_num <= 7'(sab_pkg::ADDR_MAX));
            remote_cmd_en <= !sync2[8];
            traffic_led <= (addr_num == 7'h00) || u_rx_busy || u_tx_busy;
            rx_overrun <= push && !fifo_in_ready; // a full queue drops the character
        end
    end

    sab_uart u_core (
        .clk(clk),
        .srst(srst),
        .bit_cyc(sab_pkg::BIT_CYC[eff_baud]),
        .par_mode(eff_par),
        .two_stop(eff_two),
        .rxd(line_s || u_tx_busy), // own echo ignored on the shared pair
        .rx_data(u_rx_data),
        .rx_stb(u_rx_stb),
        .rx_err(u_rx_err),
        .rx_busy(u_rx_busy),
        .gap_stb(u_gap),
        .tx_data(tx_data),
        .tx_valid(tx_valid && !hunting),
        .tx_ready(u_tx_ready),
        .txd(u_txd),
        .tx_busy(u_tx_busy)
    );
    assign link.dev_tx = u_txd;
    assign link.dev_oe = u_tx_busy;

    sab_fifo #(.WIDTH(9), .DEPTH(sab_pkg::FIFO_DEPTH)) u_rxq (
        .clk(clk),
        .srst(srst),
        .in_data({first_pend, u_rx_data}),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .out_data({rx_first, rx_data}),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );
endmodule
`default_nettype wire

// [rtl/sab_client.sv]
// Purpose: client end of the serial line, driven by software over APB
// Assumes: software builds request frames, including the check word
// Notes: one character in flight each way; a full transmitter stalls the bus
`timescale 1ns/1ps
`default_nettype none
module sab_client (
    input wire logic clk,
    input wire logic srst,
    sab_link_if.cli link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    logic s1;
    logic s2;
    logic [1:0] baud_r;
    sab_pkg::sab_par_e par_r;
    logic two_r;
    logic [7:0] rx_hold;
    logic rx_full;
    logic rx_errs;
    logic [7:0] c_rx_data;
    logic c_rx_stb;
    logic c_rx_err;
    logic c_tx_ready;
    logic c_txd;
    logic c_tx_busy;

    // address decode and handshake
    wire sel_ctrl = (paddr == sab_pkg::CLI_CTRL);
    wire sel_tx = (paddr == sab_pkg::CLI_TXDATA);
    wire sel_rx = (paddr == sab_pkg::CLI_RXDATA);
    wire sel_st = (paddr == sab_pkg::CLI_STATUS);
    wire mapped = sel_ctrl || sel_tx || sel_rx || sel_st;
    wire access = psel && penable;
    wire tx_stall = sel_tx && pwrite && !c_tx_ready;
    wire done = access && !tx_stall;
    wire [31:0] rd_mux = sel_ctrl ? {27'h000_0000, two_r, 2'(par_r), baud_r} :
                         sel_rx ? {24'h00_0000, rx_hold} :
                         sel_st ? {29'h0000_0000, rx_errs, c_tx_busy, rx_full} : 32'h0000_0000;
    assign pready = !tx_stall;
    assign pslverr = access && !mapped;
    assign link.cli_tx = c_txd;
    assign link.cli_oe = c_tx_busy;

    // line input synchroniser
    always_ff @(posedge clk) begin
        if (srst) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
        end else begin
            s1 <= link.line;
            s2 <= s1;
        end
    end

    // read data captured in setup, stable through access
    always_ff @(posedge clk) begin
        if (srst) prdata <= 32'h0000_0000;
        else if (psel && !penable) prdata <= rd_mux;
    end

    // framing register; parity code 3 reads back as none
    always_ff @(posedge clk) begin
        if (srst) begin
            baud_r <= sab_pkg::RESET_BAUD;
            par_r <= sab_pkg::PAR_EVEN;
            two_r <= 1'b0;
        end else if (done && pwrite && sel_ctrl) begin
            baud_r <= pwdata[sab_pkg::CTRL_BAUD_LSB +: 2];
            par_r <= (pwdata[sab_pkg::CTRL_PAR_LSB +: 2] == 2'h0) ? sab_pkg::PAR_EVEN :
                     (pwdata[sab_pkg::CTRL_PAR_LSB +: 2] == 2'h1) ? sab_pkg::PAR_ODD :
                     sab_pkg::PAR_NONE;
            two_r <= pwdata[sab_pkg::CTRL_TWO_STOP];
        end
    end

    // receive holding flag and sticky error: a new arrival beats the clear
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_hold <= 8'h00;
            rx_full <= 1'b0;
            rx_errs <= 1'b0;
        end else begin
            if (c_rx_stb) begin
                rx_hold <= c_rx_data;
                rx_full <= 1'b1;
            end else if (done && !pwrite && sel_rx) begin
                rx_full <= 1'b0;
            end
            if (c_rx_stb && c_rx_err) rx_errs <= 1'b1;
            else if (done && pwrite && sel_st && pwdata[sab_pkg::ST_RX_ERR]) rx_errs <= 1'b0;
        end
    end

    sab_uart u_core (
        .clk(clk),
        .srst(srst),
        .bit_cyc(sab_pkg::BIT_CYC[baud_r]),
        .par_mode(par_r),
        .two_stop(two_r && (par_r == sab_pkg::PAR_NONE)),
        .rxd(s2 || c_tx_busy), // own echo ignored
        .rx_data(c_rx_data),
        .rx_stb(c_rx_stb),
        .rx_err(c_rx_err),
        .rx_busy(),
        .gap_stb(),
        .tx_data(pwdata[7:0]),
        .tx_valid(done && pwrite && sel_tx), // one character per write
        .tx_ready(c_tx_ready),
        .txd(c_txd),
        .tx_busy(c_tx_busy)
    );
endmodule
`default_nettype wire

// [verification/sab_chk.sv]
// Purpose: serial wire checks
// Assumes: 10 MHz clock, rates from 4800 to 38400 baud
// Notes: bounds use fastest and slowest rate
`timescale 1ns/1ps
`default_nettype none
module sab_chk (
    input wire logic clk,
    input wire logic srst,
    input wire logic dev_tx,
    input wire logic dev_oe,
    input wire logic cli_tx,
    input wire logic cli_oe
);
    localparam int MIN_BIT = 259; // one cycle of slack for the sampling jitter
    logic [15:0] d_run;
    logic [15:0] c_run;
    logic [15:0] d_len;
    // level run lengths and device drive length
    always_ff @(posedge clk) begin
        d_run <= (srst || dev_tx != $past(dev_tx)) ? 16'h0001 : d_run + 16'h0001;
        c_run <= (srst || cli_tx != $past(cli_tx)) ? 16'h0001 : c_run + 16'h0001;
        d_len <= (dev_oe && !srst) ? d_len + 16'h0001 : 16'h0000;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    property p_dev_start; $rose(dev_oe) |-> !dev_tx [*8]; endproperty
    a_dev_start: assert property (p_dev_start)
        else $error("dev start bit");
    property p_dev_stop; $fell(dev_oe) |-> $past(dev_tx); endproperty
    a_dev_stop: assert property (p_dev_stop)
        else $error("dev stop level");
    property p_dev_bit; dev_oe && $past(dev_oe) && $changed(dev_tx) |-> d_run >= MIN_BIT; endproperty
    a_dev_bit: assert property (p_dev_bit)
        else $error("dev bit too short");
    property p_dev_len; $fell(dev_oe) |-> d_len >= 16'h0a26 && d_len <= 16'h5988; endproperty
    a_dev_len: assert property (p_dev_len)
        else $error("dev char length");
    property p_cli_start; $rose(cli_oe) |-> !cli_tx [*8]; endproperty
    a_cli_start: assert property (p_cli_start)
        else $error("cli start bit");
    property p_cli_stop; $fell(cli_oe) |-> $past(cli_tx); endproperty
    a_cli_stop: assert property (p_cli_stop)
        else $error("cli stop level");
    property p_cli_bit; cli_oe && $past(cli_oe) && $changed(cli_tx) |-> c_run >= MIN_BIT; endproperty
    a_cli_bit: assert property (p_cli_bit)
        else $error("cli bit too short");
    property p_quiet; $fell(srst) |-> !dev_oe && !cli_oe ##1 !dev_oe; endproperty
    a_quiet: assert property (p_quiet)
        else $error("line driven after reset");
endmodule
`default_nettype wire

// [verification/test_serial_line_autobaud_config.sv]
// Purpose: bench joining both ends
// Assumes: traffic at 38400 baud, manual mode
// Notes: a full hunt would outrun the cycle budget
`timescale 1ns/1ps
`default_nettype none
module test_serial_line_autobaud_config;
    localparam int LIM = 40000;
    logic clk, srst, psel, penable, pwrite, pready, pslverr, rerr, panel_lock, cfg_wr;
    logic cfg_auto, cfg_two_stop, rx_valid, rx_ready, rx_overrun, tx_valid, tx_ready;
    logic addr_valid, remote_cmd_en, locked, traffic_led;
    logic [7:0] paddr, tx_data, rx_data;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] addr_tens, addr_ones;
    logic [1:0] cfg_baud, cfg_parity, cur_baud, cur_parity;
    logic [6:0] station_addr;
    int bad_count, checks, ovr_cnt, oe_run, oe_last;
    sab_link_if link();
    sab_device i_sab_device (.clk, .srst, .link, .addr_tens, .addr_ones, .panel_lock, .cfg_wr,
        .cfg_auto, .cfg_baud, .cfg_parity, .cfg_two_stop, .rx_data, .rx_first(), .rx_valid,
        .rx_ready, .rx_overrun, .tx_data, .tx_valid, .tx_ready, .station_addr, .addr_valid,
        .remote_cmd_en, .locked, .cur_baud, .cur_parity, .traffic_led);
    sab_client i_sab_client (.clk, .srst, .link, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr);
    sab_chk i_sab_chk (.clk, .srst, .dev_tx(link.dev_tx), .dev_oe(link.dev_oe),
        .cli_tx(link.cli_tx), .cli_oe(link.cli_oe));
    // clock, overrun count, device drive length
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rx_overrun === 1'b1) ovr_cnt++;
        if (link.dev_oe === 1'b1) oe_run++;
        else if (oe_run != 0) begin
            oe_last = oe_run;
            oe_run = 0;
        end
    end
    task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task complete_run();
        if (bad_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // a wait that ran out ends the run at once
    task guard(input string nm, input int n);
        if (n >= LIM) begin
            check(nm, 32'h0000_0000, 32'h0000_0001);
            complete_run();
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(negedge clk);
        for (n = 0; n < LIM && pready !== 1'b1; n++)
            @(negedge clk);
        guard("pready", n);
        rdat = prdata;
        rerr = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task panel(input logic [3:0] t, input logic [3:0] o, input logic lk);
        addr_tens <= t;
        addr_ones <= o;
        panel_lock <= lk;
        repeat (5) @(posedge clk);
    endtask
    task set_cfg(input logic [1:0] b, input logic [1:0] p, input logic two);
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_auto <= 1'b0;
        cfg_baud <= b;
        cfg_parity <= p;
        cfg_two_stop <= two;
        @(posedge clk);
        cfg_wr <= 1'b0;
        apb(1'b1, sab_pkg::CLI_CTRL, {27'h000_0000, two, p, b});
        check("cur_baud", cur_baud, b);
        check("cur_parity", cur_parity, p);
        check("station", {remote_cmd_en, station_addr}, 8'h95);
    endtask
    // one character each way, drive length measured
    task t_xfer(input logic [1:0] p, input logic two, input int nb);
        int n;
        set_cfg(2'h3, p, two);
        apb(1'b1, sab_pkg::CLI_TXDATA, {30'h0000_0016, p});
        for (n = 0; n < LIM && rx_valid !== 1'b1; n++)
            @(posedge clk);
        guard("rx_valid", n);
        check("dev rx", rx_data, {6'h16, p});
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
        oe_last = 0;
        tx_data <= {7'h61, two};
        tx_valid <= 1'b1;
        @(negedge clk);
        for (n = 0; n < LIM && tx_ready !== 1'b1; n++)
            @(negedge clk);
        guard("tx_ready", n);
        @(posedge clk);
        tx_valid <= 1'b0;
        rdat = 0;
        for (n = 0; n < LIM / 4 && rdat[0] !== 1'b1; n++)
            apb(1'b0, sab_pkg::CLI_STATUS, 32'h0000_0000);
        guard("rx_full", 4 * n);
        apb(1'b0, sab_pkg::CLI_RXDATA, 32'h0000_0000);
        check("cli rx", rdat, {7'h61, two});
        for (n = 0; n < LIM && oe_last == 0; n++)
            @(posedge clk);
        guard("oe_last", n);
        n = nb * int'(sab_pkg::BIT_CYC[3]);
        check("oe width", oe_last >= n - 2 && oe_last <= n + 3, 1'h1);
    endtask
    task t_fill();
        int n;
        ovr_cnt = 0;
        for (int i = 0; i < 17; i++)
            apb(1'b1, sab_pkg::CLI_TXDATA, 32'h0000_0010 + i);
        for (n = 0; n < LIM && ovr_cnt == 0; n++)
            @(posedge clk);
        guard("overrun", n);
        for (int i = 0; i < 16; i++) begin
            @(negedge clk);
            check("fifo", {rx_valid, rx_data}, 9'h110 + i);
            @(posedge clk);
            rx_ready <= 1'b1;
            @(posedge clk);
            rx_ready <= 1'b0;
        end
        @(negedge clk);
        check("drained", {ovr_cnt[3:0], rx_valid}, 5'h02);
    endtask
    initial begin
        {srst, cfg_auto} = 2'h3;
        {psel, penable, pwrite, paddr, pwdata, panel_lock, cfg_wr, cfg_baud} = '0;
        {cfg_parity, cfg_two_stop, rx_ready, tx_data, tx_valid} = '0;
        {addr_tens, addr_ones} = 8'h21;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        repeat (5) @(posedge clk);
        check("hunting", {locked, tx_ready, cur_baud, cur_parity}, 6'h00);
        check("addr", {addr_valid, traffic_led, station_addr}, 9'h115);
        panel(4'h0, 4'h0, 1'b1);
        check("zero", {addr_valid, traffic_led, remote_cmd_en}, 3'h2);
        panel(4'h9, 4'h9, 1'b0);
        check("top", {addr_valid, remote_cmd_en, station_addr}, 9'h1e3);
        panel(4'h2, 4'h1, 1'b0);
        for (int b = 0; b < 3; b++)
            set_cfg(b[1:0], 2'h0, 1'b0);
        t_xfer(2'h1, 1'b0, 11);
        t_xfer(2'h2, 1'b0, 10);
        t_xfer(2'h2, 1'b1, 11);
        t_xfer(2'h0, 1'b0, 11);
        check("idle led", traffic_led, 1'h0);
        t_fill();
        apb(1'b1, 8'h10, 32'h0000_00ff);
        check("bad wr", rerr, 1'h1);
        apb(1'b0, 8'h10, 32'h0000_0000);
        check("bad rd", {rerr, rdat[7:0]}, 9'h100);
        apb(1'b0, sab_pkg::CLI_CTRL, 32'h0000_0000);
        check("ctrl", {rerr, rdat[4:0]}, 6'h03);
        complete_run();
    end
endmodule
`default_nettype wire
